// ---- src/dsrs_pkg.sv ----
// Shared constants and types for the dual supply reset supervisor
package dsrs_pkg;

  // Output drive styles selectable at build time
  typedef enum logic [1:0] {
    DSRS_OUT_HIGH_PP  = 2'b00,
    DSRS_OUT_LOW_PP   = 2'b01,
    DSRS_OUT_LOW_OD   = 2'b10
  } dsrs_style_t;

  // Clock rate and hold time
  localparam int unsigned CLOCK_HZ      = 10_000_000;
  localparam int unsigned HOLD_MS       = 140;
  localparam longint unsigned HOLD_CYCLES_L =
    (longint'(CLOCK_HZ) * HOLD_MS + 999) / 1000;
  localparam int unsigned HOLD_CYCLES   = int'(HOLD_CYCLES_L);

  // Glitch filter length in cycles (transient rejection)
  localparam int unsigned FILTER_NS     = 1000;
  localparam int unsigned FILTER_CYCLES =
    (FILTER_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

  // Reset values
  localparam logic        SYNC_RST_VAL  = 1'b0;
  localparam logic        ASSERT_RST    = 1'b1;

  // Raw supply and switch levels from the comparators and pin
  typedef struct packed {
    logic mainGood;
    logic senseGood;
    logic manualResetN;
  } dsrs_inputs_t;

  // Reset pin drive
  typedef struct packed {
    logic level;
    logic enable;
  } dsrs_pin_t;

endpackage : dsrs_pkg

// ---- src/dsrs_supervisor.sv ----
// What this block does
// - Reset held asserted from power-on until released
// - Either supply low asserts reset
// - Hold reset 140ms after supplies recover
// - Build-time output style: high, low, open-drain
// - Manual reset low asserts reset at once
// - Manual release waits at least 140ms
// - Unconnected manual reset reads inactive
// - Sense input fault resets like main fault
// - Brief supply glitches are rejected
module dsrs_supervisor
  import dsrs_pkg::*;
#(
  parameter dsrs_pkg::dsrs_style_t STYLE  = dsrs_pkg::DSRS_OUT_LOW_OD,
  parameter int unsigned           HOLD   = dsrs_pkg::HOLD_CYCLES,
  parameter int unsigned           FILTER = dsrs_pkg::FILTER_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire dsrs_pkg::dsrs_inputs_t rawIn,
  input  wire logic                  manualResetNOe,
  output dsrs_pkg::dsrs_pin_t        resetPin,
  output logic                       resetActive
);
  import dsrs_pkg::*;

  localparam int CW = $clog2(HOLD + 1);

  typedef enum logic [1:0] {
    ST_FAULT = 2'b00,
    ST_HOLD  = 2'b01,
    ST_RUN   = 2'b10
  } dsrs_state_t;

  logic [3:0]  syncBits;
  logic        mainBad;
  logic        senseBad;
  logic        fault;
  logic [CW-1:0] holdCount;
  logic [CW-1:0] next_holdCount;
  dsrs_state_t state;
  dsrs_state_t next_state;
  logic        asserted;
  logic        next_asserted;
  dsrs_pin_t   next_pin;
  logic        manualAct;

  // Pins cross into the clock domain before any logic reads them
  dsrs_sync #(
    .WIDTH     (4),
    .RESET_BIT (SYNC_RST_VAL)
  ) uSync (
    .clock   (clock),
    .srst    (srst),
    .asyncIn ({rawIn.mainGood, rawIn.senseGood, rawIn.manualResetN,
               manualResetNOe}),
    .syncOut (syncBits)
  );

  // Each supply is filtered on its own; brief dips never reach the timer
  dsrs_glitch_filter #(
    .FILTER    (FILTER),
    .RESET_VAL (ASSERT_RST)
  ) uMainFilter (
    .clock    (clock),
    .srst     (srst),
    .levelIn  (~syncBits[3]),
    .levelOut (mainBad)
  );

  dsrs_glitch_filter #(
    .FILTER    (FILTER),
    .RESET_VAL (ASSERT_RST)
  ) uSenseFilter (
    .clock    (clock),
    .srst     (srst),
    .levelIn  (~syncBits[2]),
    .levelOut (senseBad)
  );

  // Either supply fault holds reset; an open manual pin reads high
  assign fault     = mainBad | senseBad;
  assign manualAct = ~(syncBits[1] | ~syncBits[0]);

  // Hold sequencer: fault, timed hold, released
  always_comb begin
    next_state = state;
    next_holdCount = holdCount;
    next_asserted = 1'b1;
    unique case (state)
      ST_FAULT: begin
        next_holdCount = '0;
        if (!fault && !manualAct) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (fault || manualAct) begin
          next_state = ST_FAULT;
          next_holdCount = '0;
        end else if (holdCount >= CW'(HOLD - 1)) begin
          next_state = ST_RUN;
          next_asserted = 1'b0;
        end else begin
          next_holdCount = holdCount + CW'(1);
        end
      end
      ST_RUN: begin
        next_asserted = 1'b0;
        if (fault || manualAct) begin
          next_state = ST_FAULT;
          next_asserted = 1'b1;
        end
      end
      default: begin
        next_state = ST_FAULT;
      end
    endcase
    if (manualAct) begin
      next_asserted = 1'b1;
    end
  end

  // Output encoding by build-time style
  always_comb begin
    unique case (STYLE)
      DSRS_OUT_HIGH_PP: next_pin = '{level: next_asserted, enable: 1'b1};
      DSRS_OUT_LOW_PP:  next_pin = '{level: ~next_asserted, enable: 1'b1};
      default:          next_pin = '{level: 1'b0,
                                     enable: next_asserted};
    endcase
  end

  // State registers; reset forces asserted output
  always_ff @(posedge clock) begin
    if (srst) begin
      holdCount   <= '0;
      state       <= ST_FAULT;
      asserted    <= ASSERT_RST;
      resetPin    <= (STYLE == DSRS_OUT_HIGH_PP) ? 2'h3 :
                     (STYLE == DSRS_OUT_LOW_PP) ? 2'h1 : 2'h1;
    end else begin
      holdCount   <= next_holdCount;
      state       <= next_state;
      asserted    <= next_asserted;
      resetPin    <= next_pin;
    end
  end

  assign resetActive = asserted;

endmodule // dsrs_supervisor

// Two-flop synchroniser for levels arriving from outside the clock domain
module dsrs_sync
  import dsrs_pkg::*;
#(
  parameter int unsigned WIDTH     = 1,
  parameter logic        RESET_BIT = SYNC_RST_VAL
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import dsrs_pkg::*;

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  // First stage may go metastable; only the second stage reads it
  always_comb begin
    next_stage1 = asyncIn;
    next_stage2 = stage1;
  end

  // Synchroniser stages
  always_ff @(posedge clock) begin
    if (srst) begin
      stage1 <= {WIDTH{RESET_BIT}};
      stage2 <= {WIDTH{RESET_BIT}};
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign syncOut = stage2;

endmodule // dsrs_sync

// Passes a level change only once it has stood for FILTER cycles
module dsrs_glitch_filter
  import dsrs_pkg::*;
#(
  parameter int unsigned FILTER    = FILTER_CYCLES,
  parameter logic        RESET_VAL = ASSERT_RST
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic levelIn,
  output logic      levelOut
);
  import dsrs_pkg::*;

  // FILTER must be at least one; one passes any single clean sample
  localparam int FW = $clog2(FILTER + 1);

  logic          held;
  logic          next_held;
  logic [FW-1:0] count;
  logic [FW-1:0] next_count;

  // Disagreeing samples are counted; any agreement starts the count again
  always_comb begin
    next_held  = held;
    next_count = '0;
    if (levelIn != held) begin
      if (count >= FW'(FILTER - 1)) begin
        next_held = levelIn;
      end else begin
        next_count = count + FW'(1);
      end
    end
  end

  // Filter registers; reset reports the fault side
  always_ff @(posedge clock) begin
    if (srst) begin
      held  <= RESET_VAL;
      count <= '0;
    end else begin
      held  <= next_held;
      count <= next_count;
    end
  end

  assign levelOut = held;

endmodule // dsrs_glitch_filter

// ---- tb/dsrs_props.sv ----
module dsrs_props
  import dsrs_pkg::*;
#(
  parameter int unsigned HOLD   = 20,
  parameter int unsigned FILTER = 2
) (
  input wire logic                   clock,
  input wire logic                   srst,
  input wire dsrs_pkg::dsrs_inputs_t rawIn,
  input wire logic                   manualResetNOe,
  input wire dsrs_pkg::dsrs_pin_t    resetPin,
  input wire logic                   resetActive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic manN, ok;
  int   okCnt, next_okCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Quiet time since the last cause
  assign manN = !manualResetNOe || rawIn.manualResetN;
  assign ok = manN && rawIn.mainGood && rawIn.senseGood;
  always_comb next_okCnt = (srst || !ok) ? 0 : okCnt + 1;
  always_ff @(posedge clock) okCnt <= next_okCnt;
  a_power_on: assert property ($fell(srst) |-> resetActive)
    else $error("reset not held after power-on");
  a_main_low: assert property (
    !rawIn.mainGood[*5] |-> ##[0:2] resetActive)
    else $error("main fault missed");
  a_sense_low: assert property (
    !rawIn.senseGood[*5] |-> ##[0:2] resetActive)
    else $error("sense fault missed");
  a_manual_now: assert property (!manN |-> ##[1:3] resetActive)
    else $error("manual reset missed");
  a_hold_min: assert property ($fell(resetActive) |-> okCnt >= HOLD)
    else $error("released early");
  a_hold_max: assert property (okCnt == HOLD + 10 |-> !resetActive)
    else $error("release overdue");
  a_od_level: assert property (!resetPin.level)
    else $error("open-drain drove high");
  a_od_enable: assert property (resetPin.enable == resetActive)
    else $error("pull-down mismatch");
  c_release: cover property ($fell(resetActive));
  c_manual: cover property (!manN ##1 manN);
  c_sense: cover property (!rawIn.senseGood ##1 rawIn.senseGood);
endmodule // dsrs_props

bind dsrs_supervisor dsrs_props #(.HOLD(HOLD), .FILTER(FILTER)) uProps (
  .clock(clock), .srst(srst), .rawIn(rawIn),
  .manualResetNOe(manualResetNOe), .resetPin(resetPin),
  .resetActive(resetActive));

// ---- tb/dsrs_proc.sv ----
module dsrs_proc
  import dsrs_pkg::*;
(
  input  wire dsrs_pkg::dsrs_pin_t resetPin,
  output logic                     procResetN
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board pull-up wins while the driver floats
  assign procResetN = resetPin.enable ? resetPin.level : 1'b1;
endmodule // dsrs_proc

// ---- tb/dsrs_tb.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dsrs_pkg::*;
  logic         clock = 0, srst = 1, oe = 1, procResetN, resetActive;
  dsrs_inputs_t rawIn = 3'h7;
  dsrs_pin_t    resetPin;
  int           bad_count = 0, comparisons = 0;
  // {main, sense, manual, driven, expected}
  logic [4:0]   rows [6] = '{5'h1E, 5'h0F, 5'h17, 5'h1B, 5'h18, 5'h1E};
  // Clock and watchdog
  initial forever #50 clock = ~clock;
  initial begin
    #100000 bad_count++;
    tally_and_finish();
  end
  dsrs_supervisor #(.HOLD(20), .FILTER(2)) dut (.clock(clock), .srst(srst),
    .rawIn(rawIn), .manualResetNOe(oe), .resetPin(resetPin),
    .resetActive(resetActive));
  dsrs_proc proc (.resetPin(resetPin), .procResetN(procResetN));
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(logic s, logic e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Power-on, table rows, glitch, hold restart
  initial begin
    repeat (20) @(posedge clock);
    srst <= 0;
    tick(18);
    check(resetActive, 1);
    tick(20);
    check(procResetN, 1);
    $display("power-on done");
    foreach (rows[i]) begin
      @(posedge clock) {rawIn, oe} <= rows[i][4:1];
      tick(40);
      check(resetActive, rows[i][0]);
      check(procResetN, !rows[i][0]);
      $display("row %0d done", i);
    end
    @(posedge clock) rawIn.mainGood <= 0;
    @(posedge clock) rawIn.mainGood <= 1;
    tick(10);
    check(resetActive, 0);
    $display("glitch done");
    repeat (2) begin
      @(posedge clock) rawIn.manualResetN <= 0;
      @(posedge clock) rawIn.manualResetN <= 1;
      tick(15);
    end
    check(resetActive, 1);
    tick(15);
    check(resetActive, 0);
    $display("restart done");
    tally_and_finish();
  end
endmodule // testbench
